// file: verilog/fhr_pkg.sv
// Shared constants for the flash reset and output-disable link
package fhr_pkg;
	localparam int CLK_NS = 100;
	localparam int T_IDLE_DONE_NS = 500;
	localparam int T_ABORT_NS = 5000;
	localparam int T_ABORT_MIN_NS = 1000;
	localparam int T_ABORT_MAX_NS = 7000;
	localparam int T_WAIT_BUSY_NS = 11000;
	localparam int IDLE_DONE_CYC = (T_IDLE_DONE_NS / CLK_NS < 1) ? 1 : T_IDLE_DONE_NS / CLK_NS;
	localparam int ABORT_CYC = T_ABORT_NS / CLK_NS;
	localparam int WAIT_IDLE_CYC = (T_IDLE_DONE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAIT_BUSY_CYC = (T_WAIT_BUSY_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_CYC = 20;
	localparam int ERASE_CYC = 200;
	localparam int RST_PULSE_CYC = 4;
	localparam int WR_GAP_CYC = 6;
	localparam int RD_CYC = 6;
	localparam int GUARD_CYC = 8;
	localparam int NUM_BANKS = 2;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int CFG_W = 4;
	localparam int CFG_POS = 0;
	localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;
	localparam logic [DATA_W-1:0] CMD_PROG = 8'ha0;
	localparam logic [DATA_W-1:0] CMD_ERASE = 8'h30;
	localparam logic [DATA_W-1:0] CMD_CFG = 8'hc0;
	localparam logic [DATA_W-1:0] STATUS_BUSY = 8'h80;
	localparam logic [DATA_W-1:0] ARRAY_BASE = 8'h5a;
	typedef enum logic {FHR_ARRAY, FHR_CFG} fhr_mode_type;
	typedef enum logic [2:0] {H_PWRUP, H_RESET, H_RECOVER, H_IDLE, H_WRITE, H_READ} fhr_host_type;
endpackage

// file: verilog/fhr_link_if.sv
// Pin-level link between the flash end and the host end
interface fhr_link_if;
	import fhr_pkg::*;
	logic rst_n;
	logic ce_n;
	logic we_n;
	logic oe_n;
	logic bank;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] dq_h;
	logic dq_h_oe;
	logic [DATA_W-1:0] dq_d;
	logic dq_d_oe;
	logic rdy_o;
	logic rdy_oe;
	logic ready_busy_n;
	logic [DATA_W-1:0] dq_bus;
	// Pulled-up open-drain line and shared data bus
	assign ready_busy_n = ~(rdy_oe & ~rdy_o);
	assign dq_bus = dq_d_oe ? dq_d : dq_h;
	modport flash (input rst_n, ce_n, we_n, oe_n, bank, addr, dq_h, dq_h_oe,
		output dq_d, dq_d_oe, rdy_o, rdy_oe);
	modport host (output rst_n, ce_n, we_n, oe_n, bank, addr, dq_h, dq_h_oe,
		input dq_d, dq_d_oe, ready_busy_n, dq_bus);
endinterface

// file: verilog/fhr_flash_end.sv
// Flash end: hardware reset, abort recovery, ready/busy and output disable
// Functional notes
// - Reset low aborts, tristates, clears configuration
// - Commands ignored while reset pin low
// - Reset returns command machine to array read
// - Host reissues operations cut short by reset
// - Aborted operation holds ready/busy low 1-7 us
// - Host watches ready/busy or waits 11 us
// - Idle reset completes within 500 ns
// - Idle bank readable 500 ns after reset
// - Aborted bank untouched for 11 us; the code reopens it when ready/busy returns high, about 5 us after the abort
// - Reset held during power-up until supplies settle
// - Output enable high tristates data outputs
module fhr_flash_end #(
	parameter int PROG_LEN = fhr_pkg::PROG_CYC,
	parameter int ERASE_LEN = fhr_pkg::ERASE_CYC,
	parameter int ABORT_LEN = fhr_pkg::ABORT_CYC
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	fhr_link_if.flash LINK,
	output logic [fhr_pkg::NUM_BANKS-1:0] O_BANK_BUSY,
	output logic [fhr_pkg::CFG_W-1:0] O_CONFIG,
	output logic O_IN_RESET
);
	import fhr_pkg::*;

	localparam int PIN_W = 5 + ADDR_W + DATA_W;
	localparam int CNT_W = 8;

	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s1_reg;
	logic [PIN_W-1:0] pin_s2_reg;
	logic we_prev_reg;
	logic rst_s;
	logic ce_s;
	logic we_s;
	logic oe_s;
	logic bank_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] dq_s;
	logic pin_rst_async_n;
	logic abort;
	logic idle_done;
	logic rec_active;
	logic cmd_ok;
	logic wr_evt;
	logic rd_req;
	logic [NUM_BANKS-1:0] busy;
	logic [NUM_BANKS-1:0] hold_reg;
	logic [NUM_BANKS-1:0] start_prog;
	logic [NUM_BANKS-1:0] start_erase;
	logic [CNT_W-1:0] op_cnt_reg [NUM_BANKS];
	logic [CNT_W-1:0] rec_cnt_reg;
	logic [CNT_W-1:0] idle_cnt_reg;
	logic [CFG_W-1:0] cfg_reg;
	fhr_mode_type mode_reg;
	logic rd_en_reg;
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_data_next;
	logic bank_held;
	logic bank_busy;

	// Pin inputs pass two flip-flops
	assign pin_raw = {LINK.rst_n, LINK.ce_n, LINK.we_n, LINK.oe_n, LINK.bank, LINK.addr,
		LINK.dq_h};

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			we_prev_reg <= 1'b1;
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			we_prev_reg <= pin_s2_reg[PIN_W-3];
		end
	end

	assign rst_s = pin_s2_reg[PIN_W-1];
	assign ce_s = pin_s2_reg[PIN_W-2];
	assign we_s = pin_s2_reg[PIN_W-3];
	assign oe_s = pin_s2_reg[PIN_W-4];
	assign bank_s = pin_s2_reg[PIN_W-5];
	assign addr_s = pin_s2_reg[DATA_W +: ADDR_W];
	assign dq_s = pin_s2_reg[DATA_W-1:0];

	// Asynchronous clear from the reset pin, level held while low
	assign pin_rst_async_n = I_RST_N & LINK.rst_n;

	// Abort is seen on the synchronised pin
	assign abort = ~rst_s;
	assign idle_done = (idle_cnt_reg == '0);
	assign rec_active = (rec_cnt_reg != '0);
	assign cmd_ok = rst_s & idle_done;
	assign wr_evt = cmd_ok & ~ce_s & ~we_s & we_prev_reg;
	assign bank_held = hold_reg[bank_s];
	assign bank_busy = busy[bank_s];
	assign rd_req = cmd_ok & ~ce_s & ~oe_s & we_s & ~bank_held;

	// Per-bank program and erase engines
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			assign busy[b] = (op_cnt_reg[b] != '0);
			assign start_prog[b] = wr_evt & (mode_reg == FHR_ARRAY) & (dq_s == CMD_PROG)
				& (bank_s == 1'(b)) & ~busy[b] & ~hold_reg[b];
			assign start_erase[b] = wr_evt & (mode_reg == FHR_ARRAY) & (dq_s == CMD_ERASE)
				& (bank_s == 1'(b)) & ~busy[b] & ~hold_reg[b];

			always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
				if (!I_RST_N) begin
					op_cnt_reg[b] <= '0;
				end else if (abort) begin
					op_cnt_reg[b] <= '0;
				end else if (start_prog[b]) begin
					op_cnt_reg[b] <= CNT_W'(PROG_LEN);
				end else if (start_erase[b]) begin
					op_cnt_reg[b] <= CNT_W'(ERASE_LEN);
				end else if (busy[b]) begin
					op_cnt_reg[b] <= op_cnt_reg[b] - 1'b1;
				end
			end

			// Aborted bank stays closed until internal reset finishes
			always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
				if (!I_RST_N) begin
					hold_reg[b] <= 1'b0;
				end else if (abort & busy[b]) begin
					hold_reg[b] <= 1'b1;
				end else if (!rec_active) begin
					hold_reg[b] <= 1'b0;
				end
			end
		end
	endgenerate

	// Internal reset time after an aborted operation
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rec_cnt_reg <= '0;
		end else if (abort & (|busy)) begin
			rec_cnt_reg <= CNT_W'(ABORT_LEN);
		end else if (rec_active) begin
			rec_cnt_reg <= rec_cnt_reg - 1'b1;
		end
	end

	// Idle reset completes within its short window
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			idle_cnt_reg <= CNT_W'(IDLE_DONE_CYC);
		end else if (abort) begin
			idle_cnt_reg <= CNT_W'(IDLE_DONE_CYC);
		end else if (!idle_done) begin
			idle_cnt_reg <= idle_cnt_reg - 1'b1;
		end
	end

	// Ready/busy is open drain, pulled low while busy
	assign LINK.rdy_o = 1'b0;
	assign LINK.rdy_oe = (|busy) | rec_active;

	// Read data source
	assign rd_data_next = (mode_reg == FHR_CFG) ? {{(DATA_W-CFG_W){1'b0}}, cfg_reg} :
		bank_busy ? STATUS_BUSY :
		(ARRAY_BASE ^ {{(DATA_W-ADDR_W-1){1'b0}}, bank_s, addr_s});

	// Configuration, command mode and read enable cleared at once by the pin
	always_ff @(posedge I_CLK_SYS or negedge pin_rst_async_n) begin
		if (!pin_rst_async_n) begin
			cfg_reg <= CFG_RESET;
			mode_reg <= FHR_ARRAY;
			rd_en_reg <= 1'b0;
		end else begin
			rd_en_reg <= rd_req;
			if (wr_evt) begin
				unique case (mode_reg)
					FHR_ARRAY: begin
						if (dq_s == CMD_CFG) begin
							mode_reg <= FHR_CFG;
						end
					end
					FHR_CFG: begin
						cfg_reg <= dq_s[CFG_POS +: CFG_W];
						mode_reg <= FHR_ARRAY;
					end
				endcase
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rd_data_reg <= '0;
		end else if (rd_req) begin
			rd_data_reg <= rd_data_next;
		end
	end

	// Output drivers drop at once on reset pin or output enable high
	assign LINK.dq_d = rd_data_reg;
	assign LINK.dq_d_oe = rd_en_reg & LINK.rst_n & ~LINK.oe_n;

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_BANK_BUSY <= '0;
			O_CONFIG <= CFG_RESET;
			O_IN_RESET <= 1'b1;
		end else begin
			O_BANK_BUSY <= busy | hold_reg;
			O_CONFIG <= cfg_reg;
			O_IN_RESET <= ~cmd_ok;
		end
	end
endmodule

// file: verilog/fhr_host_end.sv
// Host end: power-up reset, reset recovery waits, reissue and bus cycles
module fhr_host_end #(
	parameter int WAIT_BUSY_LEN = fhr_pkg::WAIT_BUSY_CYC
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	fhr_link_if.host LINK,
	input wire logic I_POWER_GOOD,
	input wire logic I_RESET_REQ,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_BANK,
	input wire logic [fhr_pkg::ADDR_W-1:0] I_ADDR,
	input wire logic [fhr_pkg::DATA_W-1:0] I_DATA,
	output logic O_READY,
	output logic [fhr_pkg::DATA_W-1:0] O_RD_DATA,
	output logic O_RD_VALID
);
	import fhr_pkg::*;

	localparam int CNT_W = 8;

	fhr_host_type state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [3:0] guard_reg;
	logic [1:0] pg_sync_reg;
	logic [1:0] rdy_sync_reg;
	logic [DATA_W-1:0] dq_s1_reg;
	logic [DATA_W-1:0] dq_s2_reg;
	logic pg_s;
	logic rdy_s;
	logic pend_reg;
	logic wait_busy_reg;
	logic reissue_reg;
	logic pend_bank_reg;
	logic [ADDR_W-1:0] pend_addr_reg;
	logic [DATA_W-1:0] pend_data_reg;
	logic rst_n_reg;
	logic ce_n_reg;
	logic we_n_reg;
	logic oe_n_reg;
	logic bank_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] dq_reg;
	logic is_op;
	logic rec_done;
	logic pulse_done;

	assign LINK.rst_n = rst_n_reg;
	assign LINK.ce_n = ce_n_reg;
	assign LINK.we_n = we_n_reg;
	assign LINK.oe_n = oe_n_reg;
	assign LINK.bank = bank_reg;
	assign LINK.addr = addr_reg;
	assign LINK.dq_h = dq_reg;
	assign LINK.dq_h_oe = ~we_n_reg;
	assign O_READY = (state_reg == H_IDLE);

	assign pg_s = pg_sync_reg[1];
	assign rdy_s = rdy_sync_reg[1];
	assign is_op = (I_DATA == CMD_PROG) | (I_DATA == CMD_ERASE);
	assign pulse_done = (cnt_reg >= CNT_W'(RST_PULSE_CYC - 1));
	// With an operation pending, leave recovery on ready/busy high once the idle wait has passed, or after the worst-case wait; otherwise after the idle wait
	assign rec_done = wait_busy_reg ?
		((cnt_reg >= CNT_W'(WAIT_BUSY_LEN - 1)) | (rdy_s & (cnt_reg >= CNT_W'(WAIT_IDLE_CYC - 1)))) :
		(cnt_reg >= CNT_W'(WAIT_IDLE_CYC - 1));

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pg_sync_reg <= '0;
			rdy_sync_reg <= '0;
			dq_s1_reg <= '0;
			dq_s2_reg <= '0;
		end else begin
			pg_sync_reg <= {pg_sync_reg[0], I_POWER_GOOD};
			rdy_sync_reg <= {rdy_sync_reg[0], LINK.ready_busy_n};
			dq_s1_reg <= LINK.dq_bus;
			dq_s2_reg <= dq_s1_reg;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_reg <= H_PWRUP;
			cnt_reg <= '0;
			guard_reg <= '0;
			pend_reg <= 1'b0;
			wait_busy_reg <= 1'b0;
			reissue_reg <= 1'b0;
			pend_bank_reg <= 1'b0;
			pend_addr_reg <= '0;
			pend_data_reg <= '0;
			rst_n_reg <= 1'b0;
			ce_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			bank_reg <= 1'b0;
			addr_reg <= '0;
			dq_reg <= '0;
			O_RD_DATA <= '0;
			O_RD_VALID <= 1'b0;
		end else begin
			O_RD_VALID <= 1'b0;
			if (guard_reg != '0) begin
				guard_reg <= guard_reg - 1'b1;
			end else if (rdy_s & rst_n_reg & (state_reg != H_RECOVER)) begin
				pend_reg <= 1'b0;
			end
			unique case (state_reg)
				H_PWRUP: begin
					rst_n_reg <= 1'b0;
					cnt_reg <= pg_s ? cnt_reg + 1'b1 : '0;
					if (pg_s & pulse_done) begin
						state_reg <= H_RECOVER;
						rst_n_reg <= 1'b1;
						cnt_reg <= '0;
						wait_busy_reg <= 1'b0;
					end
				end
				H_RESET: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (pulse_done) begin
						state_reg <= H_RECOVER;
						rst_n_reg <= 1'b1;
						cnt_reg <= '0;
						reissue_reg <= pend_reg;
					end
				end
				H_RECOVER: begin
					if (cnt_reg != '1) begin
						cnt_reg <= cnt_reg + 1'b1;
					end
					if (rec_done) begin
						state_reg <= H_IDLE;
						cnt_reg <= '0;
					end
				end
				H_IDLE: begin
					cnt_reg <= '0;
					if (I_RESET_REQ) begin
						state_reg <= H_RESET;
						rst_n_reg <= 1'b0;
						wait_busy_reg <= pend_reg;
					end else if (reissue_reg) begin
						state_reg <= H_WRITE;
						reissue_reg <= 1'b0;
						pend_reg <= 1'b1;
						guard_reg <= 4'(GUARD_CYC);
						ce_n_reg <= 1'b0;
						we_n_reg <= 1'b0;
						bank_reg <= pend_bank_reg;
						addr_reg <= pend_addr_reg;
						dq_reg <= pend_data_reg;
					end else if (I_WR) begin
						state_reg <= H_WRITE;
						ce_n_reg <= 1'b0;
						we_n_reg <= 1'b0;
						bank_reg <= I_BANK;
						addr_reg <= I_ADDR;
						dq_reg <= I_DATA;
						if (is_op) begin
							pend_reg <= 1'b1;
							guard_reg <= 4'(GUARD_CYC);
							pend_bank_reg <= I_BANK;
							pend_addr_reg <= I_ADDR;
							pend_data_reg <= I_DATA;
						end
					end else if (I_RD) begin
						state_reg <= H_READ;
						ce_n_reg <= 1'b0;
						oe_n_reg <= 1'b0;
						bank_reg <= I_BANK;
						addr_reg <= I_ADDR;
					end
				end
				H_WRITE: begin
					ce_n_reg <= 1'b1;
					we_n_reg <= 1'b1;
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg >= CNT_W'(WR_GAP_CYC - 1)) begin
						state_reg <= H_IDLE;
					end
				end
				H_READ: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg >= CNT_W'(RD_CYC - 1)) begin
						state_reg <= H_IDLE;
						ce_n_reg <= 1'b1;
						oe_n_reg <= 1'b1;
						O_RD_DATA <= dq_s2_reg;
						O_RD_VALID <= 1'b1;
					end
				end
				default: begin
					state_reg <= H_PWRUP;
				end
			endcase
		end
	end
endmodule

// file: test/fhr_link_properties.sv
// Concurrent checks on the flash reset link
module fhr_link_properties (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic rst_n,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic dq_h_oe,
	input wire logic dq_d_oe,
	input wire logic rdy_oe,
	input wire logic ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rst_prev_reg;
	logic rec_wait_reg;
	// Abort recovery window, from reset release until ready/busy returns high
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_prev_reg <= 1'b0;
			rec_wait_reg <= 1'b0;
		end else begin
			rst_prev_reg <= rst_n;
			rec_wait_reg <= !ready_busy_n && (rec_wait_reg || (rst_n && !rst_prev_reg));
		end
	end
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RST_N);
	AST_RST_TRISTATE: assert property (!rst_n |-> !dq_d_oe)
		else $error("data driven in reset");
	AST_OE_TRISTATE: assert property (oe_n |-> !dq_d_oe)
		else $error("data driven with output disabled");
	AST_NO_CLASH: assert property (dq_d_oe |-> !dq_h_oe)
		else $error("both ends drive data");
	AST_NO_START_IN_RST: assert property ($rose(rdy_oe) |-> rst_n && $past(rst_n, 5))
		else $error("operation started near reset");
	AST_ABORT_BUSY: assert property ($fell(rst_n) && !ready_busy_n
		|=> (!ready_busy_n) [*8] ##[1:70] ready_busy_n)
		else $error("abort busy time wrong");
	AST_IDLE_RESET: assert property ($fell(rst_n) && ready_busy_n |-> ready_busy_n [*6])
		else $error("idle reset went busy");
	AST_HOST_WAIT: assert property ($rose(rst_n) && !ready_busy_n
		|-> ##[0:120] ready_busy_n)
		else $error("abort recovery too long");
	AST_HOST_HOLD_OFF: assert property (rec_wait_reg |-> ce_n)
		else $error("access before abort recovery");
	AST_IDLE_READ_GAP: assert property ($rose(rst_n) |-> ce_n [*5])
		else $error("access within recovery time");
	AST_RST_PULSE: assert property ($rose(rst_n) |-> !$past(rst_n, 4))
		else $error("reset pulse too short");
endmodule

// file: test/test_flash_hw_reset_output_disable.sv
// Testbench for the flash reset and output-disable link
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_flash_hw_reset_output_disable;
	import fhr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic sys_rst_n = 1'b0;
	logic power_good = 1'b0;
	logic reset_req = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic bank = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] data = '0;
	logic ready;
	logic [DATA_W-1:0] rd_data;
	logic rd_valid;
	logic [NUM_BANKS-1:0] bank_busy;
	logic [CFG_W-1:0] config_val;
	logic in_reset;
	int num_errors = 0;
	int total_checks = 0;
	always #50 clk = ~clk;
	fhr_link_if i_fhr_link_if ();
	fhr_flash_end i_fhr_flash_end (.I_CLK_SYS(clk), .I_RST_N(sys_rst_n), .LINK(i_fhr_link_if),
		.O_BANK_BUSY(bank_busy), .O_CONFIG(config_val), .O_IN_RESET(in_reset));
	fhr_host_end i_fhr_host_end (.I_CLK_SYS(clk), .I_RST_N(sys_rst_n), .LINK(i_fhr_link_if),
		.I_POWER_GOOD(power_good), .I_RESET_REQ(reset_req), .I_WR(wr), .I_RD(rd), .I_BANK(bank),
		.I_ADDR(addr), .I_DATA(data), .O_READY(ready), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid));
	fhr_link_properties i_fhr_link_properties (.I_CLK_SYS(clk), .I_RST_N(sys_rst_n),
		.rst_n(i_fhr_link_if.rst_n), .ce_n(i_fhr_link_if.ce_n), .oe_n(i_fhr_link_if.oe_n),
		.dq_h_oe(i_fhr_link_if.dq_h_oe), .dq_d_oe(i_fhr_link_if.dq_d_oe),
		.rdy_oe(i_fhr_link_if.rdy_oe), .ready_busy_n(i_fhr_link_if.ready_busy_n));
	function automatic logic [DATA_W-1:0] arr(input logic b, input logic [ADDR_W-1:0] a);
		return ARRAY_BASE ^ DATA_W'({b, a});
	endfunction
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ready !== 1'b1 && n < 400);
		`CHK("host ready", 1'b1, ready)
	endtask
	// Waits for the busy line to clear (sel 0) or for bank 1 to turn busy (sel 1)
	task automatic wait_for(input int sel, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(sel == 0 ? i_fhr_link_if.ready_busy_n === 1'b1 : bank_busy[1] === 1'b1)
			&& n < lim);
		`CHK("awaited level", 1'b1, (sel == 0 ? i_fhr_link_if.ready_busy_n : bank_busy[1]))
	endtask
	task automatic host_op(input logic w, input logic b, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		wait_ready();
		@(posedge clk);
		wr <= w;
		rd <= ~w;
		bank <= b;
		addr <= a;
		data <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rd_chk(input logic b, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		int n;
		n = 0;
		host_op(1'b0, b, a, 8'h00);
		while (rd_valid !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		`CHK("read data", e, rd_data)
	endtask
	task automatic host_reset();
		wait_ready();
		@(posedge clk);
		reset_req <= 1'b1;
		@(posedge clk);
		reset_req <= 1'b0;
		repeat (4) @(negedge clk);
		`CHK("reset pin", 1'b0, i_fhr_link_if.rst_n)
		`CHK("data drive", 1'b0, i_fhr_link_if.dq_d_oe)
		`CHK("config", CFG_RESET, config_val)
		`CHK("in reset", 1'b1, in_reset)
	endtask
	initial begin
		#(20000 * 100);
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge clk);
		sys_rst_n <= 1'b1;
		repeat (20) @(negedge clk);
		`CHK("reset pin held", 1'b0, i_fhr_link_if.rst_n)
		`CHK("host ready", 1'b0, ready)
		@(posedge clk);
		power_good <= 1'b1;
		wait_ready();
		`CHK("config", CFG_RESET, config_val)
		$display("test power_up done");
		for (int i = 0; i < 4; i++) begin
			rd_chk(i[0], ADDR_W'(i * 5), arr(i[0], ADDR_W'(i * 5)));
		end
		$display("test array_read done");
		host_op(1'b1, 1'b0, 4'h0, CMD_CFG);
		host_op(1'b1, 1'b0, 4'h0, 8'h09);
		wait_ready();
		`CHK("config", 4'h9, config_val)
		host_reset();
		rd_chk(1'b0, 4'h3, arr(1'b0, 4'h3));
		$display("test config_reset done");
		host_op(1'b1, 1'b1, 4'h2, CMD_ERASE);
		rd_chk(1'b1, 4'h2, STATUS_BUSY);
		rd_chk(1'b0, 4'h2, arr(1'b0, 4'h2));
		host_reset();
		wait_for(0, 120);
		`CHK("bank held", 2'b10, bank_busy)
		wait_ready();
		`CHK("bank held", 2'b00, bank_busy)
		wait_for(1, 80);
		wait_for(0, 400);
		rd_chk(1'b1, 4'h2, arr(1'b1, 4'h2));
		$display("test erase_abort done");
		host_op(1'b1, 1'b0, 4'h7, CMD_PROG);
		rd_chk(1'b0, 4'h7, STATUS_BUSY);
		wait_for(0, 60);
		rd_chk(1'b0, 4'h7, arr(1'b0, 4'h7));
		`CHK("data released", 1'b0, i_fhr_link_if.dq_d_oe)
		host_reset();
		`CHK("idle busy line", 1'b1, i_fhr_link_if.ready_busy_n)
		rd_chk(1'b1, 4'h7, arr(1'b1, 4'h7));
		$display("test program_idle_reset done");
		wrap_up();
	end
endmodule
